// ==== rtl/mdw_pkg.sv ====
package mdw_pkg;

   // ******************************************************
   // register map, byte addresses on the 8-bit port
   // ******************************************************
   localparam logic [7:0] MDW_ADDR_WIN_CTRL = 8'h28;
   localparam logic [7:0] MDW_ADDR_CFG = 8'h29;
   localparam logic [7:0] MDW_ADDR_PER_LO = 8'h2a;
   localparam logic [7:0] MDW_ADDR_PER_HI = 8'h2b;
   localparam logic [7:0] MDW_ADDR_STAT = 8'h2c;

   // ******************************************************
   // field positions
   // ******************************************************
   localparam int MDW_BIT_NO_PREFORMAT_GATE_WIN = 7;
   localparam int MDW_BIT_NO_SM_WIN = 6;
   localparam int MDW_BIT_NO_IDAM_WIN = 5;
   localparam int MDW_BIT_NO_DSM_WIN = 4;
   localparam int MDW_BIT_SIZE_1024 = 0;
   localparam int MDW_BIT_TOL_1P0 = 1;
   localparam int MDW_BIT_STAT_MISS = 2;

   // ******************************************************
   // reset values
   // ******************************************************
   localparam logic [7:0] MDW_CTRL_RST = 8'h00;
   localparam logic [7:0] MDW_CFG_RST = 8'h00;
   localparam logic [15:0] MDW_PERIOD_RST = 16'h02e0;

   // ******************************************************
   // timing counts in byte-times
   // ******************************************************
   localparam logic [15:0] MDW_PREFORMAT_GATE_OFF = 16'h002f; // 47 byte-times
   localparam logic [15:0] MDW_LEAD_512_P5 = 16'h0004;
   localparam logic [15:0] MDW_LEAD_1024_P5 = 16'h0008;
   localparam logic [15:0] MDW_LEAD_512_1P0 = 16'h0008;
   localparam logic [15:0] MDW_LEAD_1024_1P0 = 16'h0010;
   localparam logic [15:0] MDW_IDAM_WIN_START = 16'h0008;
   localparam logic [15:0] MDW_IDAM_WIN_END = 16'h0028;
   localparam logic [15:0] MDW_DATA_START = 16'h0030;
   localparam logic [15:0] MDW_DSM_WIN_START = 16'h003c;
   localparam logic [15:0] MDW_DSM_WIN_END = 16'h0050;

   // ******************************************************
   // types
   // ******************************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mdw_bus_s;

   typedef struct packed {
      logic sm;
      logic idam;
      logic dsm;
   } mdw_det_s;

   typedef enum logic [1:0] {
      MDW_DS_WAIT = 2'h0,
      MDW_DS_HUNT = 2'h1,
      MDW_DS_DONE = 2'h3
   } mdw_dsm_e;

   // lead of the gate ahead of the nominal sector mark
   function automatic logic [15:0] mdw_lead(input logic size_1024, input logic tol_1p0);
      logic [15:0] v;
      v = MDW_LEAD_512_P5;
      case ({tol_1p0, size_1024})
         2'h0: v = MDW_LEAD_512_P5;
         2'h1: v = MDW_LEAD_1024_P5;
         2'h2: v = MDW_LEAD_512_1P0;
         2'h3: v = MDW_LEAD_1024_1P0;
         default: v = MDW_LEAD_512_P5;
      endcase
      return v;
   endfunction : mdw_lead

endpackage : mdw_pkg

// ==== rtl/mdw_byte_timer.sv ====
`timescale 1ns/1ps
module mdw_byte_timer
   import mdw_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_byte_tick,
   input wire logic i_restart,
   input wire logic i_load,
   input wire logic [15:0] i_load_val,
   output logic [15:0] o_cnt
);

   logic [15:0] cnt_q;
   logic [15:0] cnt_d;

   // restart beats reload, reload beats counting
   assign cnt_d = i_restart ? 16'h0000 :
                  i_load ? i_load_val :
                  i_byte_tick ? cnt_q + 16'h0001 : cnt_q;

   // byte-time counter since the last sector mark
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_q <= 16'h0000;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   assign o_cnt = cnt_q;

endmodule : mdw_byte_timer

// ==== rtl/mdw_window_ctrl.sv ====
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
// Function
// RULE1: gate drops 47 bytes after sector mark
// RULE2: 0.5% tolerance lead 4 or 8 bytes
// RULE3: 1.0% tolerance lead 8 or 16 bytes
// RULE4: bit 7 holds gate continuously high
// RULE5: firmware uses continuous gate for write-once media
// RULE6: bit 6 clear windows sector mark detection
// RULE7: bit 6 set keeps sector mark detection active
// RULE8: bit 5 windows or opens address mark detection
// RULE9: bit 4 clear windows data sync detection
// RULE10: bit 4 set hunts data area until found
// RULE11: counter restarts at detected or expected mark
module mdw_window_ctrl
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_byte_tick,
   input mdw_pkg::mdw_bus_s i_bus,
   input mdw_pkg::mdw_det_s i_det,
   output logic [7:0] o_rdata,
   output logic o_preformat_gate,
   output mdw_pkg::mdw_det_s o_accept,
   output logic o_sm_window,
   output logic o_sm_missed
);
   import mdw_pkg::*;

   // ******************************************************
   // registers
   // ******************************************************
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] cfg_q;
   logic [7:0] cfg_d;
   logic [15:0] period_q;
   logic [15:0] period_d;
   logic miss_q;
   logic miss_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic gate_q;
   logic gate_d;
   mdw_det_s acc_q;
   mdw_det_s acc_d;
   logic smw_q;
   mdw_dsm_e ds_q;
   mdw_dsm_e ds_d;

   // ******************************************************
   // byte timing
   // ******************************************************
   logic [15:0] cnt;
   logic [15:0] lead;
   logic [15:0] gate_on;
   logic [15:0] win_end;
   logic sm_win;
   logic idam_win;
   logic dsm_win;
   logic pre_area;
   logic data_area;
   logic sm_miss;
   logic restart;

   // lead, rise point and end of the sector mark window
   assign lead = mdw_lead(cfg_q[MDW_BIT_SIZE_1024], cfg_q[MDW_BIT_TOL_1P0]); // RULE2 RULE3
   assign gate_on = period_q - lead;
   assign win_end = period_q + lead;

   // window decodes from the byte counter
   assign sm_win = (cnt >= gate_on) && (cnt <= win_end);
   assign idam_win = (cnt >= MDW_IDAM_WIN_START) && (cnt <= MDW_IDAM_WIN_END);
   assign dsm_win = (cnt >= MDW_DSM_WIN_START) && (cnt <= MDW_DSM_WIN_END);
   assign pre_area = cnt < MDW_PREFORMAT_GATE_OFF;
   assign data_area = (cnt >= MDW_DATA_START) && (cnt < gate_on);

   // missed mark: expected position passed plus the whole lead
   assign sm_miss = i_byte_tick && (cnt >= win_end) && !acc_d.sm; // RULE11
   assign restart = acc_d.sm; // RULE11

   mdw_byte_timer u_timer
   (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_byte_tick(i_byte_tick),
      .i_restart(restart),
      .i_load(sm_miss),
      .i_load_val(lead),
      .o_cnt(cnt)
   );

   // ******************************************************
   // detection qualification
   // ******************************************************
   logic ds_active;

   // sector mark: window or always open
   assign acc_d.sm = i_det.sm && (ctrl_q[MDW_BIT_NO_SM_WIN] || sm_win); // RULE6 RULE7
   // address mark: own window or the whole preformatted area
   assign acc_d.idam = i_det.idam && (ctrl_q[MDW_BIT_NO_IDAM_WIN] ? pre_area : idam_win); // RULE8
   // data sync: window, or hunt in data area until found
   assign ds_active = ctrl_q[MDW_BIT_NO_DSM_WIN] ? ((ds_q == MDW_DS_HUNT) && data_area) : dsm_win; // RULE9 RULE10
   assign acc_d.dsm = i_det.dsm && ds_active;

   // data sync hunt state per sector
   always_comb
   begin
      ds_d = ds_q;
      case (ds_q)
         MDW_DS_WAIT: ds_d = data_area ? MDW_DS_HUNT : MDW_DS_WAIT;
         MDW_DS_HUNT: ds_d = (acc_d.dsm || !data_area) ? MDW_DS_DONE : MDW_DS_HUNT; // RULE10
         MDW_DS_DONE: ds_d = MDW_DS_DONE;
         default: ds_d = MDW_DS_WAIT;
      endcase
      if (restart || sm_miss)
      begin
         ds_d = MDW_DS_WAIT;
      end
   end

   // ******************************************************
   // preformat gate
   // ******************************************************
   // low from 47 bytes after the mark until the lead point
   assign gate_d = ctrl_q[MDW_BIT_NO_PREFORMAT_GATE_WIN] ? 1'b1 : // RULE4
                   (pre_area || (cnt >= gate_on)); // RULE1

   // ******************************************************
   // register port
   // ******************************************************
   logic wr_ctrl;
   logic wr_cfg;
   logic wr_plo;
   logic wr_phi;
   logic wr_stat;

   function automatic logic hit(input mdw_bus_s b, input logic [7:0] a);
      return b.wr && (b.addr == a);
   endfunction : hit

   // write decodes
   assign wr_ctrl = hit(i_bus, MDW_ADDR_WIN_CTRL);
   assign wr_cfg = hit(i_bus, MDW_ADDR_CFG);
   assign wr_plo = hit(i_bus, MDW_ADDR_PER_LO);
   assign wr_phi = hit(i_bus, MDW_ADDR_PER_HI);
   assign wr_stat = hit(i_bus, MDW_ADDR_STAT);

   // next register values
   assign ctrl_d = wr_ctrl ? i_bus.wdata : ctrl_q;
   assign cfg_d = wr_cfg ? {6'h00, i_bus.wdata[1:0]} : cfg_q;
   assign period_d = {wr_phi ? i_bus.wdata : period_q[15:8], wr_plo ? i_bus.wdata : period_q[7:0]};
   // a miss in the clearing cycle wins over the clear
   assign miss_d = sm_miss || (miss_q && !(wr_stat && i_bus.wdata[MDW_BIT_STAT_MISS]));

   // read mux, zero for unmapped or idle cycles
   assign rdata_d = !i_bus.rd ? 8'h00 :
                    (i_bus.addr == MDW_ADDR_WIN_CTRL) ? ctrl_q :
                    (i_bus.addr == MDW_ADDR_CFG) ? cfg_q :
                    (i_bus.addr == MDW_ADDR_PER_LO) ? period_q[7:0] :
                    (i_bus.addr == MDW_ADDR_PER_HI) ? period_q[15:8] :
                    (i_bus.addr == MDW_ADDR_STAT) ? {gate_q, smw_q, idam_win, dsm_win,
                                                     (ds_q == MDW_DS_DONE), miss_q, 2'h0} :
                    8'h00;

   // software registers
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ctrl_q <= MDW_CTRL_RST;
         cfg_q <= MDW_CFG_RST;
         period_q <= MDW_PERIOD_RST;
         miss_q <= 1'b0;
         rdata_q <= 8'h00;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         cfg_q <= cfg_d;
         period_q <= period_d;
         miss_q <= miss_d;
         rdata_q <= rdata_d;
      end
   end

   // timing outputs
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         gate_q <= 1'b1;
         acc_q <= '0;
         smw_q <= 1'b0;
         ds_q <= MDW_DS_WAIT;
      end
      else
      begin
         gate_q <= gate_d;
         acc_q <= acc_d;
         smw_q <= sm_win;
         ds_q <= ds_d;
      end
   end

   assign o_rdata = rdata_q;
   assign o_preformat_gate = gate_q;
   assign o_accept = acc_q;
   assign o_sm_window = smw_q;
   assign o_sm_missed = miss_q;

   // ******************************************************
   // assertions
   // ******************************************************
   property p_gate_forced;
      @(posedge i_sys_clk) disable iff (i_rst)
      ctrl_q[MDW_BIT_NO_PREFORMAT_GATE_WIN] |=> o_preformat_gate;
   endproperty
   a_gate_forced: assert property (p_gate_forced) else $error("gate not held high"); // RULE4

   property p_gate_drop;
      @(posedge i_sys_clk) disable iff (i_rst)
      !ctrl_q[MDW_BIT_NO_PREFORMAT_GATE_WIN] && (cnt == 16'h002f) && (gate_on > 16'h002f) |=> !o_preformat_gate;
   endproperty
   a_gate_drop: assert property (p_gate_drop) else $error("gate not dropped at 47"); // RULE1

   property p_gate_up_before_drop;
      @(posedge i_sys_clk) disable iff (i_rst)
      !ctrl_q[MDW_BIT_NO_PREFORMAT_GATE_WIN] && (cnt == 16'h002e) |=> o_preformat_gate;
   endproperty
   a_gate_up_before_drop: assert property (p_gate_up_before_drop) else $error("gate low too early"); // RULE1

   property p_lead_p5;
      @(posedge i_sys_clk) disable iff (i_rst)
      !cfg_q[MDW_BIT_TOL_1P0] |-> (lead == (cfg_q[MDW_BIT_SIZE_1024] ? 16'h0008 : 16'h0004));
   endproperty
   a_lead_p5: assert property (p_lead_p5) else $error("wrong lead at 0.5 percent"); // RULE2

   property p_lead_1p0;
      @(posedge i_sys_clk) disable iff (i_rst)
      cfg_q[MDW_BIT_TOL_1P0] |-> (lead == (cfg_q[MDW_BIT_SIZE_1024] ? 16'h0010 : 16'h0008));
   endproperty
   a_lead_1p0: assert property (p_lead_1p0) else $error("wrong lead at 1.0 percent"); // RULE3

   property p_gate_rise;
      @(posedge i_sys_clk) disable iff (i_rst)
      !ctrl_q[MDW_BIT_NO_PREFORMAT_GATE_WIN] && (cnt == period_q - lead) |=> o_preformat_gate;
   endproperty
   a_gate_rise: assert property (p_gate_rise) else $error("gate not raised at lead point"); // RULE2

   property p_sm_windowed;
      @(posedge i_sys_clk) disable iff (i_rst)
      i_det.sm && !ctrl_q[MDW_BIT_NO_SM_WIN] && !sm_win |=> !o_accept.sm;
   endproperty
   a_sm_windowed: assert property (p_sm_windowed) else $error("mark taken outside window"); // RULE6

   property p_sm_open;
      @(posedge i_sys_clk) disable iff (i_rst)
      i_det.sm && ctrl_q[MDW_BIT_NO_SM_WIN] |=> o_accept.sm ##1 (cnt == 16'h0000) || $past(i_byte_tick);
   endproperty
   a_sm_open: assert property (p_sm_open) else $error("mark dropped with window off"); // RULE7

   property p_idam;
      @(posedge i_sys_clk) disable iff (i_rst)
      i_det.idam |=> (o_accept.idam == $past(ctrl_q[MDW_BIT_NO_IDAM_WIN] ? pre_area : idam_win));
   endproperty
   a_idam: assert property (p_idam) else $error("address mark qualification wrong"); // RULE8

   property p_dsm_windowed;
      @(posedge i_sys_clk) disable iff (i_rst)
      i_det.dsm && !ctrl_q[MDW_BIT_NO_DSM_WIN] && !dsm_win |=> !o_accept.dsm;
   endproperty
   a_dsm_windowed: assert property (p_dsm_windowed) else $error("sync taken outside window"); // RULE9

   property p_dsm_once;
      @(posedge i_sys_clk) disable iff (i_rst)
      ctrl_q[MDW_BIT_NO_DSM_WIN] && acc_d.dsm && !restart |=> (ds_q == MDW_DS_DONE) ##0 !acc_d.dsm;
   endproperty
   a_dsm_once: assert property (p_dsm_once) else $error("sync hunt not stopped"); // RULE10

   property p_restart;
      @(posedge i_sys_clk) disable iff (i_rst)
      acc_d.sm |=> (cnt == 16'h0000);
   endproperty
   a_restart: assert property (p_restart) else $error("counter not restarted"); // RULE11

   property p_miss_load;
      @(posedge i_sys_clk) disable iff (i_rst)
      sm_miss |=> (cnt == $past(lead)) && o_sm_missed;
   endproperty
   a_miss_load: assert property (p_miss_load) else $error("missed mark not handled"); // RULE11

endmodule : mdw_window_ctrl

// ==== dv/mdw_read_channel_model.sv ====
`timescale 1ns/1ps
module mdw_read_channel_model
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input mdw_pkg::mdw_det_s i_fire,
   output logic o_byte_tick,
   output mdw_pkg::mdw_det_s o_det
);
   import mdw_pkg::*;

   // ******************************************************
   // byte clock and mark pulses of the read channel
   // ******************************************************
   logic [1:0] div_q;

   // one byte-time lasts four system clocks
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         div_q <= 2'h0;
      else
         div_q <= div_q + 2'h1;
   end

   // marks appear only on a byte boundary and last one cycle
   assign o_byte_tick = (div_q == 2'h3);
   assign o_det = i_fire & {3{o_byte_tick}};
endmodule : mdw_read_channel_model

// ==== dv/mark_detection_window_control_tb.sv ====
`timescale 1ns/1ps
module mark_detection_window_control_tb;
   import mdw_pkg::*;

   // ******************************************************
   // signals
   // ******************************************************
   localparam logic [15:0] PER = 16'h0064; // short sector keeps the run brief
   localparam mdw_det_s SM = 3'h4;
   localparam mdw_det_s ID = 3'h2;
   localparam mdw_det_s DS = 3'h1;
   localparam mdw_det_s NO = 3'h0;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   mdw_bus_s bus = '0;
   mdw_det_s fire = '0;
   logic tick;
   mdw_det_s det;
   mdw_det_s acc;
   logic [7:0] rdata;
   logic gate;
   logic sm_win;
   logic missed;
   int mismatches = 0;
   int checked = 0;
   int tk = 0;
   int leads[4] = '{4, 8, 8, 16};

   // clock and the two parties
   always #5 i_sys_clk = ~i_sys_clk;
   mdw_read_channel_model u_chan (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_fire(fire), .o_byte_tick(tick),
      .o_det(det));
   mdw_window_ctrl DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_byte_tick(tick), .i_bus(bus), .i_det(det),
      .o_rdata(rdata), .o_preformat_gate(gate), .o_accept(acc), .o_sm_window(sm_win), .o_sm_missed(missed));

   // byte-times seen since the last accepted sector mark
   always @(negedge i_sys_clk)
      if (tick === 1'b1) tk = tk + 1;

   // ******************************************************
   // shared tasks
   // ******************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_sys_clk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
      @(posedge i_sys_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_sys_clk);
      bus.rd <= 1'b0;
      @(negedge i_sys_clk);
      chk(16'(rdata), 16'(exp), msg);
   endtask : chk_rd

   // wait until the byte count has reached c
   task automatic go(input int c);
      int n;
      n = 0;
      while (tk < c && n < 5000)
      begin
         @(negedge i_sys_clk);
         #1;
         n++;
      end
      // a byte clock that stops must not let the scenario go on quietly
      if (tk < c)
      begin
         mismatches++;
         $display("BAD %0t byte count %0d never reached", $time, c);
      end
   endtask : go

   // wait for gate (which 0) or missed flag (which 1) to reach v
   task automatic wait_lvl(input int which, input logic v);
      int n;
      n = 0;
      // first look only once the edge that ended the last bus cycle has settled
      @(negedge i_sys_clk);
      #1;
      while (((which == 0) ? gate : missed) !== v && n < 2000)
      begin
         @(negedge i_sys_clk);
         #1;
         n++;
      end
      if (((which == 0) ? gate : missed) !== v)
      begin
         mismatches++;
         $display("BAD %0t level %0d never reached", $time, which);
      end
   endtask : wait_lvl

   // raise marks k at the next byte boundary and judge what is accepted
   task automatic shoot(input mdw_det_s k, input mdw_det_s exp, input string msg);
      @(posedge i_sys_clk);
      fire <= k;
      do @(negedge i_sys_clk); while (tick !== 1'b1);
      @(posedge i_sys_clk);
      fire <= NO;
      @(negedge i_sys_clk);
      chk(16'(acc), 16'(exp), msg);
      if (acc.sm === 1'b1) tk = 0;
   endtask : shoot

   // align the sector with an open window, then set the control byte
   task automatic sync(input logic [7:0] c);
      wr(MDW_ADDR_WIN_CTRL, 8'h40);
      shoot(SM, SM, "sync mark");
      wr(MDW_ADDR_WIN_CTRL, c);
   endtask : sync

   // ******************************************************
   // scenarios
   // ******************************************************
   task automatic t_regs();
      chk_rd(MDW_ADDR_WIN_CTRL, MDW_CTRL_RST, "ctrl reset");
      chk_rd(MDW_ADDR_CFG, MDW_CFG_RST, "cfg reset");
      chk_rd(MDW_ADDR_PER_LO, MDW_PERIOD_RST[7:0], "period lo reset");
      chk_rd(MDW_ADDR_PER_HI, MDW_PERIOD_RST[15:8], "period hi reset");
      wr(8'h30, 8'hff);
      chk_rd(8'h30, 8'h00, "unmapped read");
      wr(MDW_ADDR_WIN_CTRL, 8'haf);
      chk_rd(MDW_ADDR_WIN_CTRL, 8'haf, "ctrl rw");
      wr(MDW_ADDR_CFG, 8'hff);
      chk_rd(MDW_ADDR_CFG, 8'h03, "cfg mask");
      wr(MDW_ADDR_PER_LO, PER[7:0]);
      wr(MDW_ADDR_PER_HI, PER[15:8]);
      chk_rd(MDW_ADDR_PER_LO, PER[7:0], "period lo");
      wr(MDW_ADDR_WIN_CTRL, 8'h00);
      $display("test regs done");
   endtask : t_regs

   task automatic t_gate(input int cfg);
      wr(MDW_ADDR_CFG, 8'(cfg));
      sync(8'h00);
      wait_lvl(0, 1'b0);
      chk(16'(tk), 16'd47, "gate fall");
      chk(16'(sm_win), 16'h0, "window shut at fall");
      wait_lvl(0, 1'b1);
      chk(16'(tk), PER - 16'(leads[cfg]), "gate rise");
      chk(16'(sm_win), 16'h1, "window open at rise");
      $display("test gate cfg %0d done", cfg);
   endtask : t_gate

   task automatic t_miss();
      wr(MDW_ADDR_CFG, 8'h00);
      sync(8'h00);
      wr(MDW_ADDR_STAT, 8'h04);
      wait_lvl(1, 1'b1);
      chk(16'(tk), PER + 16'd5, "miss moment");
      chk_rd(MDW_ADDR_STAT, 8'h84, "miss status");
      wait_lvl(0, 1'b0);
      chk(16'(tk), PER + 16'd48, "fall after miss");
      wr(MDW_ADDR_STAT, 8'h04);
      @(negedge i_sys_clk);
      chk(16'(missed), 16'h0, "miss cleared");
      $display("test miss done");
   endtask : t_miss

   task automatic t_sm();
      sync(8'h00);
      go(20);
      shoot(SM, NO, "sm outside window");
      go(96);
      shoot(SM, SM, "sm at window edge");
      wr(MDW_ADDR_WIN_CTRL, 8'h40);
      go(30);
      shoot(SM, SM, "sm open window");
      $display("test sm done");
   endtask : t_sm

   task automatic t_idam();
      sync(8'h00);
      go(4);
      shoot(ID, NO, "idam early");
      go(8);
      shoot(ID, ID, "idam window start");
      wr(MDW_ADDR_WIN_CTRL, 8'h20);
      go(44);
      shoot(ID, ID, "idam open area");
      go(50);
      shoot(ID, NO, "idam past area");
      $display("test idam done");
   endtask : t_idam

   task automatic t_dsm();
      sync(8'h00);
      go(55);
      shoot(DS, NO, "dsm early");
      go(60);
      shoot(DS, DS, "dsm window");
      sync(8'h10);
      go(40);
      shoot(DS, NO, "dsm before data");
      go(50);
      shoot(DS, DS, "dsm hunt");
      go(56);
      shoot(DS, NO, "dsm after found");
      $display("test dsm done");
   endtask : t_dsm

   task automatic t_cont();
      int lows;
      lows = 0;
      sync(8'hc0);
      repeat (600) @(negedge i_sys_clk) if (gate !== 1'b1) lows++;
      chk(16'(lows), 16'h0, "gate held");
      $display("test continuous gate done");
   endtask : t_cont

   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // main sequence
   initial
   begin
      repeat (5) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      tk = 0;
      @(negedge i_sys_clk);
      chk(16'(gate), 16'h1, "gate after reset");
      t_regs();
      for (int i = 0; i < 4; i++) t_gate(i);
      t_miss();
      t_sm();
      t_idam();
      t_dsm();
      t_cont();
      conclude();
   end

   // watchdog against a hang
   initial
   begin
      #200000;
      mismatches++;
      $display("BAD %0t watchdog expired", $time);
      conclude();
   end
endmodule : mark_detection_window_control_tb
